// ---- hdl/msicb_pkg.sv ----
// Functional notes
// [R1] header byte 7:0 reads constant 05h
// [R2] next pointer bits 15:8 read 00h
// [R3] enable clear: legacy pin interrupts only
// [R4] enable set: messages, input pins ignored
// [R5] requested count field 19:17 reads 000
// [R6] granted count field 22:20 writable, resets 000
// [R7] low address bits 31:2 writable, 1:0 zero
// [R8] upper address writable; bit 23 resets one
// [R9] data bits 15:0 writable, 31:16 zero
// [R10] enabled event issues write, 64-bit if upper nonzero
//
// package for the message interrupt capability block: offsets, fields,
// reset values and the structs carried between the bus front end, core and link.
// assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
package msicb_pkg;

  localparam int ADDR_W = 12;                          // bus byte address width

  // register byte offsets
  localparam logic [11:0] OFF_HEADER   = 12'h0F0;      // id, next pointer, control
  localparam logic [11:0] OFF_ADDR_LO  = 12'h0F4;      // message address low
  localparam logic [11:0] OFF_ADDR_HI  = 12'h0F8;      // message address high
  localparam logic [11:0] OFF_PAYLOAD  = 12'h0FC;      // message data
  localparam logic [11:0] OFF_IRQ_STAT = 12'h000;      // sticky event status, w1c
  localparam logic [11:0] OFF_IRQ_MASK = 12'h004;      // event mask
  localparam logic [11:0] OFF_STATE    = 12'h008;      // live state, read only

  // header word fields
  localparam logic [7:0]  CAP_ID       = 8'h05;        // capability identifier
  localparam logic [7:0]  NEXT_PTR     = 8'h00;        // end of list
  localparam int          EN_BIT       = 16;           // message enable
  localparam int          REQ_LSB      = 17;           // requested count, 3 bits
  localparam int          GRANT_LSB    = 20;           // granted count, 3 bits
  localparam int          CAP64_BIT    = 23;           // 64-bit address capable
  localparam logic [2:0]  REQ_CODE     = 3'h0;         // one vector requested
  localparam logic [2:0]  GRANT_RST    = 3'h0;
  localparam logic        CAP64_RST    = 1'b1;
  localparam logic        EN_RST       = 1'b0;

  // address and data register layouts
  localparam logic [31:0] ADDR_LO_MASK = 32'hFFFFFFFC;  // bits 1:0 read zero
  localparam logic [31:0] PAYLOAD_MASK = 32'h0000FFFF;  // bits 31:16 read zero
  localparam logic [31:0] WORD_RST     = 32'h00000000;

  // interrupt status / mask bit positions
  localparam int          EV_SENT      = 0;            // message accepted by link
  localparam int          EV_DROP      = 1;            // request lost while busy
  localparam int          EV_LEGACY    = 2;            // legacy pin rose while disabled
  localparam int          EV_W         = 3;
  localparam logic [2:0]  EV_RST       = 3'h0;

  // bus response codes
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // one register write, handed from front end to core
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } msicb_wr_t;

  // one outgoing memory write toward the root complex
  typedef struct packed {
    logic [63:0] addr;
    logic [31:0] data;
    logic        is64;
  } msicb_msg_t;

endpackage

// ---- hdl/msicb_axil_slave.sv ----
// AXI4-Lite slave front end for the capability block.
// assumes the core decodes addresses combinationally and answers within
// the cycle; one write and one read in flight at a time.
`timescale 1ns/10ps
module msicb_axil_slave
(
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output msicb_pkg::msicb_wr_t      wrReq,
  output logic                      wrStrobe,
  input  wire logic                 wrHit,
  output logic [11:0]               rdAddr,
  input  wire logic [31:0]          rdData,
  input  wire logic                 rdHit
);

  logic        awHeld_reg;   // write address captured
  logic        wHeld_reg;    // write data captured
  logic [11:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        bValid_reg;
  logic [1:0]  bResp_reg;
  logic        rValid_reg;
  logic [31:0] rData_reg;
  logic [1:0]  rResp_reg;

  // channels take items independently; both stall while a response waits
  assign s_axi_awready = !awHeld_reg && !bValid_reg;
  assign s_axi_wready  = !wHeld_reg && !bValid_reg;
  assign s_axi_arready = !rValid_reg;

  // the write fires in the first cycle that both halves are held
  assign wrStrobe = awHeld_reg && wHeld_reg && !bValid_reg;
  assign wrReq    = '{addr: awAddr_reg, data: wData_reg, strb: wStrb_reg};
  assign rdAddr   = s_axi_araddr;

  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp  = bResp_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata  = rData_reg;
  assign s_axi_rresp  = rResp_reg;

  // write path: capture address and data in either order, then answer
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= '0;
      wData_reg  <= '0;
      wStrb_reg  <= '0;
      bValid_reg <= 1'b0;
      bResp_reg  <= msicb_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrStrobe)
      begin
        // unmapped addresses are answered, never hung
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bValid_reg <= 1'b1;
        bResp_reg  <= wrHit ? msicb_pkg::RESP_OKAY : msicb_pkg::RESP_SLVERR;
      end
      else if (bValid_reg && s_axi_bready)
        bValid_reg <= 1'b0;
    end
  end

  // read path: data sampled at the address handshake
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rValid_reg <= 1'b0;
      rData_reg  <= '0;
      rResp_reg  <= msicb_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rValid_reg <= 1'b1;
      rData_reg  <= rdHit ? rdData : 32'h00000000;
      rResp_reg  <= rdHit ? msicb_pkg::RESP_OKAY : msicb_pkg::RESP_SLVERR;
    end
    else if (rValid_reg && s_axi_rready)
      rValid_reg <= 1'b0;
  end

endmodule

// ---- hdl/msicb_top.sv ----
// message signalled interrupt capability: registers, legacy pin path,
// and the memory-write message issuer toward the root complex.
// assumes intxPins are asynchronous pins; msgRequest comes from core logic
// on core_clk; the link side accepts a message on msgValid && msgReady.
`timescale 1ns/10ps
module msicb_top
(
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // register bus
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // legacy interrupt pins in, and their forwarded level out
  input  wire logic [3:0]           intxPins,
  output logic [3:0]                intxOut,
  // interrupt condition from bridge logic
  input  wire logic                 msgRequest,
  input  wire logic [4:0]           msgVector,
  // outgoing message write
  output msicb_pkg::msicb_msg_t     msgOut,
  output logic                      msgValid,
  input  wire logic                 msgReady,
  // block interrupt
  output logic                      irq
);

  typedef enum logic [0:0] {MSICB_IDLE, MSICB_SEND} msicb_state_t;

  // byte-enable merge, used by every writable register except the w1c status
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = newVal[8*i +: 8];
    end
    return res;
  endfunction

  // vector bits that the granted count lets the device alter
  function automatic logic [4:0] vecMask(input logic [2:0] code);
    logic [4:0] m;
    unique case (code)
      3'h0:    m = 5'h00;
      3'h1:    m = 5'h01;
      3'h2:    m = 5'h03;
      3'h3:    m = 5'h07;
      3'h4:    m = 5'h0F;
      3'h5:    m = 5'h1F;
      default: m = 5'h00;   // reserved codes fall back to one vector
    endcase
    return m;
  endfunction

  // front-end wires
  msicb_pkg::msicb_wr_t wrReq;
  logic                 wrStrobe;
  logic                 wrHit;
  logic [11:0]          rdAddr;
  logic [31:0]          rdData;
  logic                 rdHit;

  // capability registers
  logic                 enable_reg;            // message mode when set
  logic [2:0]           grant_reg;             // granted vector count code
  logic                 cap64_reg;             // 64-bit capable flag
  logic [31:0]          addrLo_reg;
  logic [31:0]          addrHi_reg;
  logic [31:0]          payload_reg;

  // event status and mask
  logic [2:0]           status_reg;
  logic [2:0]           status_next;
  logic [2:0]           mask_reg;

  // pin synchroniser and edge memory
  logic [3:0]           pinMeta_reg;           // first stage, read only by second
  logic [3:0]           pinSync_reg;
  logic [3:0]           pinPrev_reg;

  // message issuer
  msicb_state_t         state_reg;
  logic                 pending_reg;           // request waiting to go out
  logic [4:0]           vector_reg;
  msicb_pkg::msicb_msg_t msg_reg;

  msicb_axil_slave u_slave
  (
    .core_clk      (core_clk),
    .reset         (reset),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wrReq         (wrReq),
    .wrStrobe      (wrStrobe),
    .wrHit         (wrHit),
    .rdAddr        (rdAddr),
    .rdData        (rdData),
    .rdHit         (rdHit)
  );

  // write decode
  wire wrHeader  = wrStrobe && (wrReq.addr == msicb_pkg::OFF_HEADER);
  wire wrAddrLo  = wrStrobe && (wrReq.addr == msicb_pkg::OFF_ADDR_LO);
  wire wrAddrHi  = wrStrobe && (wrReq.addr == msicb_pkg::OFF_ADDR_HI);
  wire wrPayload = wrStrobe && (wrReq.addr == msicb_pkg::OFF_PAYLOAD);
  wire wrStat    = wrStrobe && (wrReq.addr == msicb_pkg::OFF_IRQ_STAT);
  wire wrMask    = wrStrobe && (wrReq.addr == msicb_pkg::OFF_IRQ_MASK);
  // read-only registers still take writes silently
  assign wrHit = (wrReq.addr == msicb_pkg::OFF_HEADER) || (wrReq.addr == msicb_pkg::OFF_ADDR_LO)
              || (wrReq.addr == msicb_pkg::OFF_ADDR_HI) || (wrReq.addr == msicb_pkg::OFF_PAYLOAD)
              || (wrReq.addr == msicb_pkg::OFF_IRQ_STAT) || (wrReq.addr == msicb_pkg::OFF_IRQ_MASK)
              || (wrReq.addr == msicb_pkg::OFF_STATE);

  // header word as software sees it
  wire [31:0] headerWord = {8'h00,                       // upper control bits read zero
                            cap64_reg,                   // R8
                            grant_reg,                   // R6
                            msicb_pkg::REQ_CODE,         // R5
                            enable_reg,
                            msicb_pkg::NEXT_PTR,         // R2
                            msicb_pkg::CAP_ID};          // R1
  wire [31:0] headerMerged = mergeBytes(headerWord, wrReq.data, wrReq.strb);
  wire [31:0] addrLoNext   = mergeBytes(addrLo_reg, wrReq.data, wrReq.strb)
                             & msicb_pkg::ADDR_LO_MASK;  // R7
  wire [31:0] payloadNext  = mergeBytes(payload_reg, wrReq.data, wrReq.strb)
                             & msicb_pkg::PAYLOAD_MASK;  // R9
  wire [31:0] maskMerged   = mergeBytes({29'h00000000, mask_reg}, wrReq.data, wrReq.strb);
  wire [31:0] stateWord    = {24'h000000, pinSync_reg, 2'h0,
                              (state_reg == MSICB_SEND), pending_reg};

  // read decode
  wire selHdr = (rdAddr == msicb_pkg::OFF_HEADER);
  wire selLo  = (rdAddr == msicb_pkg::OFF_ADDR_LO);
  wire selHi  = (rdAddr == msicb_pkg::OFF_ADDR_HI);
  wire selPl  = (rdAddr == msicb_pkg::OFF_PAYLOAD);
  wire selSt  = (rdAddr == msicb_pkg::OFF_IRQ_STAT);
  wire selMk  = (rdAddr == msicb_pkg::OFF_IRQ_MASK);
  wire selLv  = (rdAddr == msicb_pkg::OFF_STATE);
  assign rdHit  = selHdr | selLo | selHi | selPl | selSt | selMk | selLv;
  assign rdData = selHdr ? headerWord
                : selLo  ? addrLo_reg
                : selHi  ? addrHi_reg
                : selPl  ? payload_reg
                : selSt  ? {29'h00000000, status_reg}
                : selMk  ? {29'h00000000, mask_reg}
                : selLv  ? stateWord
                : 32'h00000000;

  // capability register writes
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      enable_reg  <= msicb_pkg::EN_RST;
      grant_reg   <= msicb_pkg::GRANT_RST;            // R6
      cap64_reg   <= msicb_pkg::CAP64_RST;            // R8
      addrLo_reg  <= msicb_pkg::WORD_RST;
      addrHi_reg  <= msicb_pkg::WORD_RST;
      payload_reg <= msicb_pkg::WORD_RST;
      mask_reg    <= msicb_pkg::EV_RST;
    end
    else
    begin
      if (wrHeader)
      begin
        // id, pointer and requested count stay fixed
        enable_reg <= headerMerged[msicb_pkg::EN_BIT];
        grant_reg  <= headerMerged[msicb_pkg::GRANT_LSB +: 3];   // R6
        cap64_reg  <= headerMerged[msicb_pkg::CAP64_BIT];        // R8
      end
      if (wrAddrLo)
        addrLo_reg <= addrLoNext;                                // R7
      if (wrAddrHi)
        addrHi_reg <= mergeBytes(addrHi_reg, wrReq.data, wrReq.strb); // R8
      if (wrPayload)
        payload_reg <= payloadNext;                              // R9
      if (wrMask)
        mask_reg <= maskMerged[2:0];
    end
  end

  // legacy pins: two flops before anything looks at them
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pinMeta_reg <= 4'h0;
      pinSync_reg <= 4'h0;
      pinPrev_reg <= 4'h0;
    end
    else
    begin
      pinMeta_reg <= intxPins;
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg;
    end
  end

  // legacy level forwarded only while messages are off
  assign intxOut = enable_reg ? 4'h0 : pinSync_reg;              // R3 R4
  wire legacyRise = !enable_reg && |(pinSync_reg & ~pinPrev_reg); // R3

  // issuer events
  wire reqTake   = enable_reg && msgRequest;                     // R4 R10
  wire launch    = (state_reg == MSICB_IDLE) && pending_reg && enable_reg;
  wire delivered = (state_reg == MSICB_SEND) && msgReady;
  wire reqDrop   = reqTake && pending_reg;                       // only one held

  // sticky status: a new event beats a same-cycle software clear
  always_comb
  begin
    status_next = status_reg;
    if (wrStat)
      status_next = status_reg & ~(wrReq.data[2:0] & {3{wrReq.strb[0]}});
    if (delivered)
      status_next[msicb_pkg::EV_SENT] = 1'b1;
    if (reqDrop)
      status_next[msicb_pkg::EV_DROP] = 1'b1;
    if (legacyRise)
      status_next[msicb_pkg::EV_LEGACY] = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      status_reg <= msicb_pkg::EV_RST;
    else
      status_reg <= status_next;
  end

  assign irq = |(status_reg & mask_reg);

  // message payload: low data bits carry the vector within the grant
  wire [4:0]  vmask    = vecMask(grant_reg);
  wire [15:0] msgData  = {payload_reg[15:5],
                          (payload_reg[4:0] & ~vmask) | (vector_reg & vmask)};
  wire        use64    = (addrHi_reg != 32'h00000000);           // R10

  // issuer: hold one request, present it until the link accepts it
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_reg   <= MSICB_IDLE;
      pending_reg <= 1'b0;
      vector_reg  <= 5'h00;
      msg_reg     <= '0;
    end
    else
    begin
      if (reqTake && !pending_reg)
      begin
        pending_reg <= 1'b1;
        vector_reg  <= msgVector;
      end
      else if (launch || !enable_reg)
        pending_reg <= 1'b0;                 // disable discards a waiting request
      unique case (state_reg)
        MSICB_IDLE:
        begin
          if (launch)
          begin
            // address and data frozen while the write is offered
            msg_reg.addr <= {use64 ? addrHi_reg : 32'h00000000, addrLo_reg}; // R10
            msg_reg.data <= {16'h0000, msgData};                             // R10
            msg_reg.is64 <= use64;                                           // R10
            state_reg    <= MSICB_SEND;
          end
        end
        MSICB_SEND:
        begin
          if (msgReady)
            state_reg <= MSICB_IDLE;
        end
      endcase
    end
  end

  assign msgValid = (state_reg == MSICB_SEND);
  assign msgOut   = msg_reg;

endmodule

// ---- tb/msicb_top_monitor.sv ----
// checker for the capability block ports: bus answer holds, read-only
// header fields, and the shape of each outgoing message write.
// assumes one core_clk domain with synchronous active-high reset.
`timescale 1ns/10ps
module msicb_top_monitor
(
  input wire logic                  core_clk,
  input wire logic                  reset,
  input wire logic [11:0]           s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire msicb_pkg::msicb_msg_t msgOut,
  input wire logic                  msgValid,
  input wire logic                  msgReady
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // read address accepted at this edge; data is visible one edge later
  wire arTake = s_axi_arvalid && s_axi_arready;
  a_hdr_id_ptr:
  assert property (arTake && s_axi_araddr == 12'h0F0 |=> s_axi_rdata[15:0] == 16'h0005)
    else $error("header id or next pointer wrong");
  a_ctrl_ro_bits:
  assert property (arTake && s_axi_araddr == 12'h0F0 |=> s_axi_rdata[31:24] == 8'h00
    && s_axi_rdata[19:17] == 3'h0) else $error("control read-only bits wrong");
  a_addr_lo_zero:
  assert property (arTake && s_axi_araddr == 12'h0F4 |=> s_axi_rdata[1:0] == 2'h0)
    else $error("low address bits 1:0 not zero");
  a_payload_hi:
  assert property (arTake && s_axi_araddr == 12'h0FC |=> s_axi_rdata[31:16] == 16'h0000)
    else $error("data bits 31:16 not zero");
  // answers must stand until the master takes them
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_msg_holds:
  assert property (msgValid && !msgReady |=> msgValid && $stable(msgOut))
    else $error("message changed before acceptance");
  a_msg_width:
  assert property (msgValid |-> msgOut.is64 == (msgOut.addr[63:32] != 32'h00000000))
    else $error("message width flag disagrees with address");
  a_msg_data_hi:
  assert property (msgValid |-> msgOut.data[31:16] == 16'h0000 && msgOut.addr[1:0] == 2'h0)
    else $error("message data or address reserved bits set");
  c_msg64: cover property (msgValid && msgReady && msgOut.is64);
  c_msg_stall: cover property (msgValid && !msgReady);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind msicb_top msicb_top_monitor u_mon (.core_clk, .reset, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .msgOut, .msgValid, .msgReady);

// ---- tb/msicb_rc_model.sv ----
// root complex stand-in: takes message writes, prompt or with a stall.
// assumes msgOut stands while msgValid is high.
`timescale 1ns/10ps
module msicb_rc_model
(
  input wire logic                  core_clk,
  input wire logic                  reset,
  input wire msicb_pkg::msicb_msg_t msgOut,
  input wire logic                  msgValid,
  output logic                      msgReady,
  input wire logic                  slowMode,
  output logic [7:0]                msgCount,
  output msicb_pkg::msicb_msg_t     lastMsg
);
  logic [2:0] waitCnt;              // cycles the current message has waited
  // slow mode holds off three cycles, so the design must keep its word
  assign msgReady = msgValid && (waitCnt >= (slowMode ? 3'h3 : 3'h0));
  // record each accepted memory write
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      waitCnt <= 3'h0;
      msgCount <= 8'h00;
    end
    else if (msgValid && msgReady)
    begin
      waitCnt <= 3'h0;
      msgCount <= msgCount + 8'h01;
      lastMsg <= msgOut;
    end
    else if (msgValid)
      waitCnt <= waitCnt + 3'h1;
  end
endmodule

// ---- tb/msicb_top_tb.sv ----
// bench for msicb_top: register rows, mid-run reset values, legacy pins,
// 32- and 64-bit message writes, irq set and clear.
// assumes the root complex model in msicb_rc_model.
`timescale 1ns/10ps
module msicb_top_tb;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [3:0] s;
    logic [31:0] e; logic [1:0] r;} msicb_row_t;
  logic core_clk = 1'b0, reset = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'h0, intxPins = 4'h0, intxOut;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, msgRequest = 1'b0;
  logic        slowMode = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, msgValid, msgReady, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [4:0]  msgVector = 5'h00;
  logic [7:0]  msgCount;
  msicb_pkg::msicb_msg_t msgOut, lastMsg;
  int          numErrors = 0, testsRun = 0, cycles = 0;
  // address, write data, strobes, read-back expected, response expected
  msicb_row_t rows [7] = '{
    '{12'h0F4, 32'hFFFFFFFF, 4'hF, 32'hFFFFFFFC, 2'h0},
    '{12'h0F8, 32'h89ABCDEF, 4'hF, 32'h89ABCDEF, 2'h0},
    '{12'h0FC, 32'hFFFFFFFF, 4'hF, 32'h0000FFFF, 2'h0},
    '{12'h0F0, 32'h00DF0000, 4'h4, 32'h00D10005, 2'h0},
    '{12'h0F0, 32'hFF000000, 4'h8, 32'h00D10005, 2'h0},
    '{12'h0F4, 32'h00000000, 4'h2, 32'hFFFF00FC, 2'h0},
    '{12'h010, 32'h00000001, 4'hF, 32'h00000000, 2'h2}}; // unmapped
  msicb_top dut (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .intxPins, .intxOut, .msgRequest,
    .msgVector, .msgOut, .msgValid, .msgReady, .irq);
  msicb_rc_model u_rc (.core_clk, .reset, .msgOut, .msgValid, .msgReady, .slowMode,
    .msgCount, .lastMsg);
  initial forever #12.5 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    testsRun++;
    if (g !== e)
    begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // each channel held until its own ready; response kept in resp
  task automatic axWrite(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axRead(input logic [11:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse();
    @(posedge core_clk);
    msgRequest <= 1'b1;
    @(posedge core_clk);
    msgRequest <= 1'b0;
  endtask
  task automatic waitMsg(input logic [7:0] n);
    while (msgCount !== n)
      @(posedge core_clk);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      numErrors++;
      close_out();
    end
  end
  initial
  begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    foreach (rows[i])
    begin
      axWrite(rows[i].a, rows[i].d, rows[i].s);
      chk("write resp", rows[i].r, resp);
      axRead(rows[i].a);
      chk("read data", rows[i].e, rd);
      chk("read resp", rows[i].r, resp);
    end
    // second reset in mid-run must restore every field of the four capability words
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      axRead(12'h0F0 + 12'(4 * i));
      chk("reset value", (i == 0) ? 32'h00800005 : 32'h0, rd);
    end
    // disabled: pins pass through, requests are ignored
    intxPins <= 4'h5;
    pulse();
    repeat (6) @(posedge core_clk);
    chk("legacy pins", 4'h5, intxOut);
    chk("no message", 8'h00, msgCount);
    axWrite(12'h0F4, 32'h12345678, 4'hF);
    axWrite(12'h0FC, 32'h0000BEEF, 4'hF);
    axWrite(12'h004, 32'h00000001, 4'hF);
    axWrite(12'h0F0, 32'h00810000, 4'h4);
    repeat (4) @(posedge core_clk);
    chk("pins ignored", 4'h0, intxOut);
    pulse();
    waitMsg(8'h01);
    chk("msg addr", 64'h12345678, lastMsg.addr);
    chk("msg data", 32'h0000BEEF, lastMsg.data);
    chk("msg width", 1'b0, lastMsg.is64);
    chk("irq sent", 1'b1, irq);
    axWrite(12'h000, 32'h00000001, 4'h1);
    repeat (2) @(posedge core_clk);
    chk("irq clear", 1'b0, irq);
    axRead(12'h000);
    chk("status legacy", 32'h00000004, rd);
    // 64-bit address, 32 vectors granted, stalling link
    slowMode <= 1'b1;
    msgVector <= 5'h13;
    axWrite(12'h0F8, 32'h00000001, 4'hF);
    axWrite(12'h0F0, 32'h00D10000, 4'h4);
    pulse();
    waitMsg(8'h02);
    chk("msg addr64", 64'h0000000112345678, lastMsg.addr);
    chk("msg vector", 32'h0000BEF3, lastMsg.data);
    chk("msg width64", 1'b1, lastMsg.is64);
    close_out();
  end
endmodule
